/* acl_pkg.sv */
// constants and types for the converter control logic
`default_nettype none
package acl_pkg;
  // register indexes; byte address is four times the index
  localparam logic [7:0] ACL_IDX_SCR = 8'h40;
  localparam logic [7:0] ACL_IDX_RES = 8'h41;
  localparam logic [7:0] ACL_IDX_CLK = 8'h42;
  // status/control fields
  localparam int ACL_BIT_DONE = 7;
  localparam int ACL_BIT_IEN  = 6;
  localparam int ACL_BIT_CONT = 5;
  // clock select fields
  localparam int ACL_BIT_DIV_LO = 5;
  localparam int ACL_BIT_SRC    = 4;
  // channel codes
  localparam logic [4:0] ACL_CH_OFF     = 5'h1F;
  localparam logic [4:0] ACL_CH_HREF_LO = 5'h1C;
  localparam logic [4:0] ACL_CH_HREF_HI = 5'h1D;
  localparam logic [4:0] ACL_CH_GND     = 5'h1E;
  localparam int         ACL_NUM_PINS   = 4;
  // reset values
  localparam logic [7:0] ACL_SCR_RST = 8'h1F;
  localparam logic [7:0] ACL_RES_RST = 8'h00;
  localparam logic [7:0] ACL_CLK_RST = 8'h00;
  // converter clock counts, last index of each phase
  localparam logic [4:0] ACL_SETTLE_LAST = 5'h0F;
  localparam logic [4:0] ACL_SAMPLE_LAST = 5'h07;
  localparam logic [4:0] ACL_TRIAL_LAST  = 5'h07;
  localparam logic [3:0] ACL_DIV_MAX     = 4'hF;
  localparam logic [7:0] ACL_SAR_MSB     = 8'h80;

  typedef enum logic [1:0] {
    ACL_IDLE,
    ACL_SETTLE,
    ACL_SAMPLE,
    ACL_TRIAL
  } acl_phase_t;

  typedef struct packed {
    logic       power_en;
    logic [4:0] chan;
    logic       chan_known;
    logic       sample;
    logic [7:0] trial;
  } acl_analog_t;

  typedef struct packed {
    logic cpu;
    logic dma;
    logic wake;
  } acl_irq_t;

  typedef struct packed {
    logic       done;
    logic       ien;
    logic       cont;
    logic [4:0] chan;
    logic [7:0] result;
    logic [2:0] div;
    logic       src;
    logic [3:0] pre;
    acl_phase_t phase;
    logic [4:0] cnt;
    logic [7:0] sar;
    logic       irq_pend;
    logic       stop_q;
    logic [1:0] xtal_s;
    logic       xtal_q;
    logic [1:0] cmp_s;
    logic [31:0] rdata;
  } acl_state_t;
endpackage
`default_nettype wire

/* acl_adc_ctrl.sv */
// apb control logic of the 8-bit successive approximation converter
// Function
// R1: interrupt enable set: request after each conversion, to cpu if select bit low
// R2: interrupt enable set and select bit high: request routed to dma
// R3: with interrupts enabled the select bit is no completion flag
// R4: converter runs in wait mode; cpu request raises wake
// R5: software turns converter off before wait if no wake needed
// R6: stop mode halts converter and drops partial result
// R7: leaving stop restarts conversions, first period is settling
// R8: status/control word: select 7, enable 6, continuous 5, channel 4..0
// R9: interrupts off: done flag read-only, set at each conversion end
// R10: done clears on status/control write or result read
// R11: interrupts on: select bit writable and readable; reset clears it
// R12: pending request drops on result read or control write; reset clears enable
// R13: continuous converts back to back; else one per write; reset clears
// R14: channel codes 0..3 pins, 1C/1D high reference, 1E ground
// R15: all ones channel powers converter off, no conversions
// R16: one conversion period of settling after leaving power off
// R17: reserved channel codes give an undefined result
// R18: result register read-only, reset zero, loaded each conversion end
// R19: prescaler divides by 1,2,4,8, or 16 when top bit set
// R20: source bit one picks bus clock, zero crystal; reset crystal
// R21: software keeps converter clock near 1 MHz
// R22: any status/control write starts a new sequence
// R23: each conversion takes 16 to 17 converter clocks
// R24: continuous results overwrite unread ones
// R25: selected pin is forced input and reads zero in port logic
// R26: eight trials msb first, one per converter clock
`default_nettype none
module acl_adc_ctrl
  import acl_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               stop_mode,
  input  wire logic               crystal_reference_clock,
  input  wire logic               cmp_in,
  output acl_pkg::acl_analog_t    analog,
  output acl_pkg::acl_irq_t       irq,
  output logic [ACL_NUM_PINS-1:0] pin_owned
);
  import acl_pkg::*;

  acl_state_t s;
  acl_state_t n;
  logic       setup;
  logic       acc;
  logic       hit;
  logic [7:0] idx;
  logic       wr_scr;
  logic       wr_clk;
  logic       rd_res;
  logic       src_tick;
  logic       tick;
  logic [3:0] ratio_last;
  logic       conv_end;
  logic [7:0] msk;
  logic [7:0] sar_new;
  logic       powered;

  assign idx    = paddr[9:2];
  assign hit    = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00) &&
                  (idx == ACL_IDX_SCR || idx == ACL_IDX_RES ||
                   idx == ACL_IDX_CLK);
  assign setup  = psel && !penable;
  assign acc    = psel && penable;
  assign wr_scr = acc && pwrite && hit && idx == ACL_IDX_SCR;
  assign wr_clk = acc && pwrite && hit && idx == ACL_IDX_CLK;
  assign rd_res = acc && !pwrite && hit && idx == ACL_IDX_RES;
  assign powered = s.chan != ACL_CH_OFF;

  always_comb
  begin
    n = s;
    tick = 1'b0;
    conv_end = 1'b0;
    msk = 8'h00;
    sar_new = s.sar;
    // synchronisers for crystal clock and comparator
    n.xtal_s = {s.xtal_s[0], crystal_reference_clock};
    n.xtal_q = s.xtal_s[1];
    n.cmp_s  = {s.cmp_s[0], cmp_in};
    n.stop_q = stop_mode;
    // prescaler
    src_tick = s.src ? 1'b1 : (s.xtal_s[1] && !s.xtal_q); // see R20
    ratio_last = s.div[2] ? ACL_DIV_MAX
                          : (4'h1 << s.div[1:0]) - 4'h1; // see R19
    if (src_tick)
    begin
      if (s.pre >= ratio_last)
      begin
        n.pre = 4'h0;
        tick = 1'b1;
      end
      else
      begin
        n.pre = s.pre + 4'h1;
      end
    end
    // conversion sequencer
    unique case (s.phase)
      ACL_IDLE:
      begin
        n.cnt = 5'h00;
      end
      ACL_SETTLE:
      begin
        if (tick)
        begin
          if (s.cnt == ACL_SETTLE_LAST) // see R7, R16
          begin
            n.phase = ACL_SAMPLE;
            n.cnt = 5'h00;
          end
          else
          begin
            n.cnt = s.cnt + 5'h01;
          end
        end
      end
      ACL_SAMPLE:
      begin
        if (tick)
        begin
          if (s.cnt == ACL_SAMPLE_LAST) // see R23
          begin
            n.phase = ACL_TRIAL;
            n.cnt = 5'h00;
            n.sar = ACL_SAR_MSB;
          end
          else
          begin
            n.cnt = s.cnt + 5'h01;
          end
        end
      end
      ACL_TRIAL:
      begin
        if (tick)
        begin
          // keep the trial bit when the input is at or above the trial level
          msk = ACL_SAR_MSB >> s.cnt[2:0]; // see R26
          sar_new = s.cmp_s[1] ? s.sar : (s.sar & ~msk);
          n.cnt = s.cnt + 5'h01;
          n.sar = sar_new | (msk >> 1);
          if (s.cnt == ACL_TRIAL_LAST)
          begin
            n.result = sar_new; // see R18, R24, R17
            conv_end = 1'b1;
            n.cnt = 5'h00;
            n.sar = sar_new;
            n.phase = s.cont ? ACL_SAMPLE : ACL_IDLE; // see R13
          end
        end
      end
    endcase
    // register writes
    if (wr_scr)
    begin
      n.ien  = pwdata[ACL_BIT_IEN];
      n.cont = pwdata[ACL_BIT_CONT];
      n.chan = pwdata[4:0];
      n.cnt  = 5'h00;
      if (pwdata[4:0] == ACL_CH_OFF)
        n.phase = ACL_IDLE; // see R15
      else if (!powered)
        n.phase = ACL_SETTLE; // see R16
      else
        n.phase = ACL_SAMPLE; // see R22
    end
    if (wr_clk)
    begin
      n.div = pwdata[ACL_BIT_DIV_LO +: 3];
      n.src = pwdata[ACL_BIT_SRC];
    end
    // done flag or routing select
    if (wr_scr)
      n.done = pwdata[ACL_BIT_IEN] & pwdata[ACL_BIT_DONE]; // see R10, R11
    else if (rd_res && !s.ien)
      n.done = 1'b0; // see R10
    if (conv_end && !n.ien)
      n.done = 1'b1; // see R9, R3
    // pending request
    if (wr_scr || rd_res)
      n.irq_pend = 1'b0; // see R12
    if (conv_end && s.ien)
      n.irq_pend = 1'b1; // see R1, R2
    // stop mode
    if (stop_mode)
    begin
      n.phase = ACL_IDLE; // see R6
      n.cnt = 5'h00;
      n.sar = 8'h00;
    end
    else if (s.stop_q && powered)
    begin
      n.phase = ACL_SETTLE; // see R7
      n.cnt = 5'h00;
    end
    // read data captured in the setup cycle
    if (setup && !pwrite && hit)
    begin
      unique case (idx)
        ACL_IDX_SCR: n.rdata = {24'h000000, s.done, s.ien, s.cont,
                                s.chan}; // see R8
        ACL_IDX_RES: n.rdata = {24'h000000, s.result};
        default:     n.rdata = {24'h000000, s.div, s.src, 4'h0};
      endcase
    end
    else if (setup)
    begin
      n.rdata = 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= '{done: ACL_SCR_RST[ACL_BIT_DONE],
             ien: ACL_SCR_RST[ACL_BIT_IEN],
             cont: ACL_SCR_RST[ACL_BIT_CONT],
             chan: ACL_SCR_RST[4:0],
             result: ACL_RES_RST,
             div: ACL_CLK_RST[ACL_BIT_DIV_LO +: 3],
             src: ACL_CLK_RST[ACL_BIT_SRC],
             pre: 4'h0,
             phase: ACL_IDLE,
             cnt: 5'h00,
             sar: 8'h00,
             irq_pend: 1'b0,
             stop_q: 1'b0,
             xtal_s: 2'b00,
             xtal_q: 1'b0,
             cmp_s: 2'b00,
             rdata: 32'h00000000};
    else
      s <= n;
  end

  // bus answer
  assign prdata  = s.rdata;
  assign pready  = 1'b1;
  assign pslverr = acc && !hit;

  // analog side
  assign analog.power_en   = powered && !s.stop_q; // see R15, R6
  assign analog.chan       = s.chan;
  assign analog.chan_known = (s.chan < 5'(ACL_NUM_PINS)) ||
                             s.chan == ACL_CH_HREF_LO ||
                             s.chan == ACL_CH_HREF_HI ||
                             s.chan == ACL_CH_GND; // see R14, R17
  assign analog.sample     = s.phase == ACL_SAMPLE;
  assign analog.trial      = s.sar;

  // request routing
  assign irq.cpu  = s.irq_pend && s.ien && !s.done; // see R1
  assign irq.dma  = s.irq_pend && s.ien && s.done; // see R2
  assign irq.wake = irq.cpu; // see R4

  // port pin takeover
  genvar i;
  generate
    for (i = 0; i < ACL_NUM_PINS; i++)
    begin : g_pin
      assign pin_owned[i] = powered && s.chan == 5'(i); // see R25
    end
  endgenerate
endmodule
`default_nettype wire

/* acl_assertions.sv */
// port assertions of the converter control logic
`default_nettype none
module acl_assertions
  import acl_pkg::*;
(
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [11:0]             paddr,
  input wire logic                    pslverr,
  input wire logic                    stop_mode,
  input wire acl_pkg::acl_analog_t    analog,
  input wire acl_pkg::acl_irq_t       irq,
  input wire logic [ACL_NUM_PINS-1:0] pin_owned
);
  timeunit 1ns;
  timeprecision 1ps;
  logic acc;
  assign acc = psel && penable;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_route; !(irq.cpu && irq.dma); endproperty
  a_route: assert property (p_route)
    else $error("cpu and dma request together");
  property p_wake; irq.wake == irq.cpu; endproperty
  a_wake: assert property (p_wake)
    else $error("wake differs from cpu request");
  property p_stop; stop_mode |=> !analog.power_en; endproperty
  a_stop: assert property (p_stop)
    else $error("converter powered in stop");
  property p_off; analog.chan == 5'h1F |-> !analog.power_en; endproperty
  a_off: assert property (p_off)
    else $error("converter powered with channel off");
  property p_rdclr; acc && !pwrite && paddr == 12'h104 |=> !irq.cpu; endproperty
  a_rdclr: assert property (p_rdclr)
    else $error("cpu request kept after result read");
  property p_wrclr; acc && pwrite && paddr == 12'h100 |=> !irq.dma; endproperty
  a_wrclr: assert property (p_wrclr)
    else $error("dma request kept after control write");
  property p_pins; pin_owned == ((analog.chan < 5'h04) ?
    4'h1 << analog.chan[1:0] : 4'h0); endproperty
  a_pins: assert property (p_pins)
    else $error("pin ownership wrong");
  property p_slverr; acc && paddr[1:0] != 2'h0 |-> pslverr; endproperty
  a_slverr: assert property (p_slverr)
    else $error("misaligned access not refused");
endmodule
`default_nettype wire

/* acl_cmp_model.sv */
// comparator model behind the input multiplexer
`default_nettype none
module acl_cmp_model
  import acl_pkg::*;
(
  input  wire acl_pkg::acl_analog_t analog,
  input  wire logic [7:0]           level,
  output logic                      cmp_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] v;
  // reference inputs fixed; powered off output wanders
  assign v = analog.chan[4:2] != 3'h7 ? level :
             analog.chan[1] ? 8'h00 : 8'hFF;
  assign cmp_in = analog.power_en ? v >= analog.trial : ~analog.trial[0];
endmodule
`default_nettype wire

/* tb_adc_control_logic.sv */
// testbench of the converter control logic
`default_nettype none
module tb_adc_control_logic
  import acl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        stop_mode = 1'b0;
  logic        xtal = 1'b0;
  logic        cmp_in;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic [7:0]  level = 8'h5A;
  logic [15:0] lfsr = 16'hBA08;
  logic [3:0]  pin_owned;
  logic [4:0]  chs [7] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h1C, 5'h1D, 5'h1E};
  acl_analog_t analog;
  acl_irq_t    irq;
  int          num_errors = 0;
  int          check_count = 0;
  int          d;
  int          n;
  int          r;
  acl_adc_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stop_mode(stop_mode), .crystal_reference_clock(xtal),
    .cmp_in(cmp_in), .analog(analog), .irq(irq), .pin_owned(pin_owned));
  acl_cmp_model u_cmp (.analog(analog), .level(level), .cmp_in(cmp_in));
  initial
  begin
    forever #2 pclk = ~pclk;
  end
  initial
  begin
    forever #11 xtal = ~xtal;
  end
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic int model(input int ch, input int lv);
    if (ch == 28 || ch == 29)
      return 255;
    return ch == 30 ? 0 : lv;
  endfunction
  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, x, input string nm);
    check_count++;
    if (s !== x)
    begin
      num_errors++;
      $display("FAIL %s exp %h seen %h", nm, x, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (n >= 50)
    begin
      num_errors++;
      end_sim;
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic wt(input bit pin);
    for (int i = 0; i < 200; i++)
    begin
      if (pin)
        @(posedge pclk);
      else
        apb(0, 12'h100, 0);
      if ((pin ? irq.cpu | irq.dma : q[7]) === 1'b1)
        return;
    end
    num_errors++;
    end_sim;
  endtask
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h100, 0);
    chk(q, 32'h1F, "scr reset");
    chk(err, 0, "scr error");
    apb(0, 12'h108, 0);
    chk(q, 32'h00, "clock reset");
    apb(1, 12'h104, 32'hAA);
    apb(0, 12'h104, 0);
    chk(q, 32'h00, "result");
    apb(0, 12'h102, 0);
    chk(q, 32'h0, "misaligned data");
    chk(err, 1, "misaligned");
    $display("test reset end");
    // divide by four: comparator sync needs three pclk per trial
    apb(1, 12'h108, 32'h50);
    foreach (chs[i])
    begin
      lfsr = nxt(lfsr);
      level <= lfsr[7:0];
      apb(1, 12'h100, {27'h0, chs[i]});
      wt(0);
      apb(0, 12'h104, 0);
      chk(q, model(chs[i], level), "result");
      chk(analog.chan_known, 1, "known channel");
      apb(0, 12'h100, 0);
      chk(q[7], 0, "done");
    end
    apb(1, 12'h100, 32'h04);
    chk(analog.chan_known, 0, "reserved channel");
    $display("test channels end");
    for (d = 0; d < 5; d++)
    begin
      r = 1 << (d == 4 ? 4 : d);
      apb(1, 12'h108, 32'h10 | d << 5);
      apb(1, 12'h100, 32'h1E);
      for (n = 0; n < 300 && analog.sample !== 1'b1; n++)
        @(posedge pclk);
      for (n = 0; n < 300 && analog.sample === 1'b1; n++)
        @(posedge pclk);
      chk(n >= 7 * r && n <= 9 * r, 1, "sample span");
    end
    apb(1, 12'h108, 32'h00);
    apb(1, 12'h100, 32'h1E);
    for (n = 0; n < 300 && analog.sample === 1'b1; n++)
      @(posedge pclk);
    chk(n >= 35 && n <= 54, 1, "crystal span");
    apb(1, 12'h108, 32'h50);
    $display("test divider end");
    apb(1, 12'h100, 32'h41);
    wt(1);
    chk(irq, 3'b101, "cpu request");
    apb(0, 12'h100, 0);
    chk(q[7], 0, "no done");
    apb(0, 12'h104, 0);
    chk(irq, 3'b000, "request");
    apb(1, 12'h100, 32'hC1);
    wt(1);
    chk(irq, 3'b010, "dma request");
    apb(0, 12'h100, 0);
    chk(q, 32'hC1, "select");
    apb(1, 12'h100, 32'h1F);
    chk({irq, analog.power_en}, 0, "off");
    $display("test requests end");
    apb(1, 12'h100, 32'h22);
    wt(0);
    lfsr = nxt(lfsr);
    level <= lfsr[7:0];
    repeat (140) @(posedge pclk);
    apb(0, 12'h104, 0);
    chk(q, level, "overwrite");
    @(posedge pclk);
    stop_mode <= 1'b1;
    apb(1, 12'h100, 32'h22);
    repeat (40) @(posedge pclk);
    apb(0, 12'h100, 0);
    chk({q[7], analog.power_en}, 0, "stopped");
    @(posedge pclk);
    stop_mode <= 1'b0;
    wt(0);
    apb(0, 12'h104, 0);
    chk(q, level, "resume");
    $display("test modes end");
    end_sim;
  end
endmodule
bind acl_adc_ctrl acl_assertions u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pslverr(pslverr), .stop_mode(stop_mode), .analog(analog), .irq(irq),
  .pin_owned(pin_owned));
`default_nettype wire
